// [verilog/gpio_regs_pkg.sv]
// Command codes, reset values and shared types of the port expander register file
package gpio_regs_pkg;

    // Command codes held in the write-only pointer
    localparam logic [7:0] REG_IN0      = 8'h00;  // Input level, port 0
    localparam logic [7:0] REG_IN1      = 8'h01;  // Input level, port 1
    localparam logic [7:0] REG_OUT0     = 8'h02;  // Output value, port 0
    localparam logic [7:0] REG_OUT1     = 8'h03;  // Output value, port 1
    localparam logic [7:0] REG_INV0     = 8'h04;  // Polarity inversion, port 0
    localparam logic [7:0] REG_INV1     = 8'h05;  // Polarity inversion, port 1
    localparam logic [7:0] REG_DIR0     = 8'h06;  // Direction, port 0
    localparam logic [7:0] REG_DIR1     = 8'h07;  // Direction, port 1
    localparam logic [7:0] REG_DRV0_LO  = 8'h40;  // Drive strength, port 0 pins 3..0
    localparam logic [7:0] REG_DRV0_HI  = 8'h41;  // Drive strength, port 0 pins 7..4
    localparam logic [7:0] REG_DRV1_LO  = 8'h42;  // Drive strength, port 1 pins 3..0
    localparam logic [7:0] REG_DRV1_HI  = 8'h43;  // Drive strength, port 1 pins 7..4
    localparam logic [7:0] REG_HOLD0    = 8'h44;  // Input hold enable, port 0
    localparam logic [7:0] REG_HOLD1    = 8'h45;  // Input hold enable, port 1
    localparam logic [7:0] REG_PULLEN0  = 8'h46;  // Pull resistor enable, port 0
    localparam logic [7:0] REG_PULLEN1  = 8'h47;  // Pull resistor enable, port 1
    localparam logic [7:0] REG_PULLSEL0 = 8'h48;  // Pull direction select, port 0
    localparam logic [7:0] REG_PULLSEL1 = 8'h49;  // Pull direction select, port 1
    localparam logic [7:0] REG_MASK0    = 8'h4A;  // Interrupt mask, port 0
    localparam logic [7:0] REG_MASK1    = 8'h4B;  // Interrupt mask, port 1
    localparam logic [7:0] REG_FLAGS0   = 8'h4C;  // Interrupt status, port 0
    localparam logic [7:0] REG_FLAGS1   = 8'h4D;  // Interrupt status, port 1
    localparam logic [7:0] REG_DRVTYPE  = 8'h4F;  // Output driver type

    // Power-up values
    localparam logic [7:0] RST_OUT      = 8'hFF;
    localparam logic [7:0] RST_INV      = 8'h00;
    localparam logic [7:0] RST_DIR      = 8'hFF;
    localparam logic [7:0] RST_DRV      = 8'hFF;
    localparam logic [7:0] RST_HOLD     = 8'h00;
    localparam logic [7:0] RST_PULLEN   = 8'h00;
    localparam logic [7:0] RST_PULLSEL  = 8'hFF;
    localparam logic [7:0] RST_MASK     = 8'hFF;
    localparam logic [7:0] RST_FLAGS    = 8'h00;
    localparam logic [7:0] RST_DRVTYPE  = 8'h00;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;  // Byte returned for an unknown code
    localparam logic [7:0] RST_PTR      = 8'h00;

    // Bit slot positions within one serial byte frame
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT      = 4'h8;

    // Serial slave protocol phase
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_CMD,
        PH_WDATA,
        PH_RDATA,
        PH_IGNORE
    } phase_t;

    // Software-visible storage
    typedef struct packed {
        logic [1:0][7:0] out_val;
        logic [1:0][7:0] invert;
        logic [1:0][7:0] direction;
        logic [3:0][7:0] drive;
        logic [1:0][7:0] hold_en;
        logic [1:0][7:0] pull_en;
        logic [1:0][7:0] pull_sel;
        logic [1:0][7:0] irq_mask;
        logic [7:0]      drv_type;
    } regs_t;

endpackage

// [verilog/gpio_expander_register_file.sv]
// Serial slave front end, command pointer and port registers of a 16-bit port expander
//
// Notes on behaviour
// - Byte after acknowledged write address loads pointer.
// - Bit six plus low nibble selects extended; the decode here compares all eight code bits.
// - Pointer is write only, never read back.
// - Codes 00h-07h: input, output, invert, direction.
// - Outputs, direction reset ones; inversion resets zeros.
// - Codes 40h-43h drive strength, reset ones.
// - Codes 44h-45h input hold, reset zeros.
// - Codes 46h-47h pull enable, reset zeros.
// - Codes 48h-49h pull select, reset ones.
// - Codes 4Ah-4Bh interrupt mask, reset ones.
// - Codes 4Ch-4Dh read-only status, reset zeros.
// - Code 4Fh driver type byte, reset zeros.
// - Input register shows pin level, any direction.
// - Writes to input registers are ignored.
// - Input registers follow pins, no reset value.
// - Output bit drives pin only as output.
// - Output register reads back written value.
// - Inversion one complements reported pin level.
// - Inversion zero reports pin level unchanged.
// - Direction one makes pin high-impedance input.
// - Direction zero makes pin driven output.
`timescale 1ns/1ps

module gpio_expander_register_file #(
    parameter logic [4:0] DEV_ADDR_HI = 5'h1D  // Fixed upper slave address bits
) (
    // System clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    // Serial bus: clock and open-drain data
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe_b,
    // Address strap pins
    input  wire logic [1:0]  i_addr_sel,
    // Port 0 pins
    input  wire logic [7:0]  i_port0_pin,
    output logic      [7:0]  o_port0_pin_out,
    output logic      [7:0]  o_port0_pin_oe_b,
    // Port 1 pins
    input  wire logic [7:0]  i_port1_pin,
    output logic      [7:0]  o_port1_pin_out,
    output logic      [7:0]  o_port1_pin_oe_b,
    // Extended pad controls
    output logic      [31:0] o_drive_strength,
    output logic      [15:0] o_hold_enable,
    output logic      [15:0] o_pull_enable,
    output logic      [15:0] o_pull_select,
    output logic      [15:0] o_irq_mask,
    output logic      [7:0]  o_output_driver_type
);

    // Complete state of the system-clock side
    typedef struct packed {
        gpio_regs_pkg::phase_t phase;     // Protocol phase
        logic [3:0]            bit_cnt;   // Bit slot within the byte frame
        logic                  ack_drv;   // Acknowledge owed in the ninth slot
        logic                  rd_dir;    // Transfer direction from address byte
        logic                  sda_low;   // Pulling the data line low
        logic [7:0]            ptr;       // Command pointer
        logic [7:0]            tx;        // Byte being shifted out
        logic                  scl_s1;    // Serial clock synchroniser
        logic                  scl_s2;
        logic                  scl_s3;    // Edge history
        logic                  sda_s1;    // Serial data synchroniser
        logic                  sda_s2;
        logic                  sda_s3;    // Edge history
        logic [15:0]           pin_s1;    // Port pin synchroniser
        logic [15:0]           pin_s2;
        logic [1:0]            adr_s1;    // Strap synchroniser
        logic [1:0]            adr_s2;
        gpio_regs_pkg::regs_t  regs;      // Register storage
    } state_t;

    // One register holds all system-clock state
    state_t     cur_ff;       // Registered state
    state_t     nxt_cur;      // Next state
    logic [7:0] rx_shift_ff;  // Bits taken on the serial clock

    // Read decode of the command pointer; the pointer itself is never a source
    function automatic logic [7:0] reg_read(
        input logic [7:0]           ptr,
        input gpio_regs_pkg::regs_t r,
        input logic [15:0]          lvl
    );
        // Result byte; unknown codes fall to the fixed value
        logic [7:0] v;
        v = gpio_regs_pkg::UNMAPPED_RD;
        case (ptr)
            // Pin level through the inversion mask, either direction
            gpio_regs_pkg::REG_IN0:      v = lvl[7:0] ^ r.invert[0];
            gpio_regs_pkg::REG_IN1:      v = lvl[15:8] ^ r.invert[1];
            gpio_regs_pkg::REG_OUT0:     v = r.out_val[0];
            gpio_regs_pkg::REG_OUT1:     v = r.out_val[1];
            gpio_regs_pkg::REG_INV0:     v = r.invert[0];
            gpio_regs_pkg::REG_INV1:     v = r.invert[1];
            gpio_regs_pkg::REG_DIR0:     v = r.direction[0];
            gpio_regs_pkg::REG_DIR1:     v = r.direction[1];
            gpio_regs_pkg::REG_DRV0_LO:  v = r.drive[0];
            gpio_regs_pkg::REG_DRV0_HI:  v = r.drive[1];
            gpio_regs_pkg::REG_DRV1_LO:  v = r.drive[2];
            gpio_regs_pkg::REG_DRV1_HI:  v = r.drive[3];
            gpio_regs_pkg::REG_HOLD0:    v = r.hold_en[0];
            gpio_regs_pkg::REG_HOLD1:    v = r.hold_en[1];
            gpio_regs_pkg::REG_PULLEN0:  v = r.pull_en[0];
            gpio_regs_pkg::REG_PULLEN1:  v = r.pull_en[1];
            gpio_regs_pkg::REG_PULLSEL0: v = r.pull_sel[0];
            gpio_regs_pkg::REG_PULLSEL1: v = r.pull_sel[1];
            gpio_regs_pkg::REG_MASK0:    v = r.irq_mask[0];
            gpio_regs_pkg::REG_MASK1:    v = r.irq_mask[1];
            // No event source here, so status stays at its power-up value
            gpio_regs_pkg::REG_FLAGS0:   v = gpio_regs_pkg::RST_FLAGS;
            gpio_regs_pkg::REG_FLAGS1:   v = gpio_regs_pkg::RST_FLAGS;
            gpio_regs_pkg::REG_DRVTYPE:  v = r.drv_type;
            default:                     v = gpio_regs_pkg::UNMAPPED_RD;
        endcase
        // One byte per code, never the pointer itself
        return v;
    endfunction

    // Serial clock domain: shift data in on each rising serial clock edge.
    // Data only; the system side reads it only after a rise it has seen,
    // while it stays stable until the next rise.
    always_ff @(posedge i_scl)
    begin
        rx_shift_ff <= {rx_shift_ff[6:0], i_sda};
    end

    // Next-state logic of the system-clock side
    always_comb
    begin
        // Local event strobes, cleared first so no latch forms
        logic scl_rise;
        logic scl_fall;
        logic start_cond;
        logic stop_cond;
        logic busy;
        scl_rise   = 1'b0;
        scl_fall   = 1'b0;
        start_cond = 1'b0;
        stop_cond  = 1'b0;
        busy       = 1'b0;
        // Hold every field unless a branch below changes it
        nxt_cur    = cur_ff;

        // Synchronisers: first stage feeds only the second
        nxt_cur.scl_s1 = i_scl;
        nxt_cur.scl_s2 = cur_ff.scl_s1;
        nxt_cur.scl_s3 = cur_ff.scl_s2;
        // Data line takes the same path as the clock
        nxt_cur.sda_s1 = i_sda;
        nxt_cur.sda_s2 = cur_ff.sda_s1;
        nxt_cur.sda_s3 = cur_ff.sda_s2;
        // Both ports sampled as one word
        nxt_cur.pin_s1 = {i_port1_pin, i_port0_pin};
        nxt_cur.pin_s2 = cur_ff.pin_s1;
        nxt_cur.adr_s1 = i_addr_sel;
        nxt_cur.adr_s2 = cur_ff.adr_s1;

        // Bus events from the synchronised lines
        scl_rise   = cur_ff.scl_s2 & ~cur_ff.scl_s3;
        scl_fall   = ~cur_ff.scl_s2 & cur_ff.scl_s3;
        start_cond = cur_ff.scl_s2 & cur_ff.scl_s3 & ~cur_ff.sda_s2 & cur_ff.sda_s3;
        stop_cond  = cur_ff.scl_s2 & cur_ff.scl_s3 & cur_ff.sda_s2 & ~cur_ff.sda_s3;
        // Only live phases count bit slots
        busy       = (cur_ff.phase != gpio_regs_pkg::PH_IDLE)
                   && (cur_ff.phase != gpio_regs_pkg::PH_IGNORE);

        if (stop_cond)
        begin
            // Stop ends the transfer and frees the line
            nxt_cur.phase   = gpio_regs_pkg::PH_IDLE;
            nxt_cur.bit_cnt = 4'h0;
            nxt_cur.ack_drv = 1'b0;
            nxt_cur.sda_low = 1'b0;
        end
        else if (start_cond)
        begin
            // Start or repeated start: expect an address byte
            nxt_cur.phase   = gpio_regs_pkg::PH_ADDR;
            nxt_cur.bit_cnt = 4'h0;
            nxt_cur.ack_drv = 1'b0;
            nxt_cur.sda_low = 1'b0;
        end
        else
        begin
            // Rising serial clock: one bit slot completed
            if (scl_rise && busy)
            begin
                if (cur_ff.bit_cnt == gpio_regs_pkg::ACK_SLOT)
                begin
                    // Ninth slot done: move to the next byte
                    nxt_cur.bit_cnt = 4'h0;
                    nxt_cur.ack_drv = 1'b0;
                    case (cur_ff.phase)
                        gpio_regs_pkg::PH_ADDR:
                        begin
                            // Read: load the first byte to send
                            if (cur_ff.rd_dir)
                            begin
                                nxt_cur.phase = gpio_regs_pkg::PH_RDATA;
                                nxt_cur.tx    = reg_read(cur_ff.ptr, cur_ff.regs, cur_ff.pin_s2);
                            end
                            else
                            begin
                                // Write: the command byte comes next
                                nxt_cur.phase = gpio_regs_pkg::PH_CMD;
                            end
                        end
                        gpio_regs_pkg::PH_CMD:
                        begin
                            // Every later byte writes the same register
                            nxt_cur.phase = gpio_regs_pkg::PH_WDATA;
                        end
                        gpio_regs_pkg::PH_RDATA:
                        begin
                            // Master not-acknowledge ends the read
                            if (rx_shift_ff[0])
                            begin
                                nxt_cur.phase = gpio_regs_pkg::PH_IGNORE;
                            end
                            else
                            begin
                                // Master acknowledged: repeat the same register
                                nxt_cur.tx = reg_read(cur_ff.ptr, cur_ff.regs, cur_ff.pin_s2);
                            end
                        end
                        default:
                        begin
                            // Other phases stay where they are
                            nxt_cur.phase = cur_ff.phase;
                        end
                    endcase
                end
                else
                begin
                    // Count the slot just finished
                    nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
                    if (cur_ff.bit_cnt == gpio_regs_pkg::LAST_DATA_BIT)
                    begin
                        // Whole byte received
                        case (cur_ff.phase)
                            gpio_regs_pkg::PH_ADDR:
                            begin
                                // Answer only our own address
                                if (rx_shift_ff[7:1] == {DEV_ADDR_HI, cur_ff.adr_s2})
                                begin
                                    nxt_cur.ack_drv = 1'b1;
                                    // Keep the direction bit for the ninth slot
                                    nxt_cur.rd_dir  = rx_shift_ff[0];
                                end
                                else
                                begin
                                    nxt_cur.phase = gpio_regs_pkg::PH_IGNORE;
                                end
                            end
                            gpio_regs_pkg::PH_CMD:
                            begin
                                // Command byte goes straight into the pointer
                                nxt_cur.ptr     = rx_shift_ff;
                                nxt_cur.ack_drv = 1'b1;
                            end
                            gpio_regs_pkg::PH_WDATA:
                            begin
                                nxt_cur.ack_drv = 1'b1;
                                // Register write; read-only and unknown codes keep all state
                                case (cur_ff.ptr)
                                    gpio_regs_pkg::REG_OUT0:     nxt_cur.regs.out_val[0]   = rx_shift_ff;
                                    gpio_regs_pkg::REG_OUT1:     nxt_cur.regs.out_val[1]   = rx_shift_ff;
                                    gpio_regs_pkg::REG_INV0:     nxt_cur.regs.invert[0]    = rx_shift_ff;
                                    gpio_regs_pkg::REG_INV1:     nxt_cur.regs.invert[1]    = rx_shift_ff;
                                    gpio_regs_pkg::REG_DIR0:     nxt_cur.regs.direction[0] = rx_shift_ff;
                                    gpio_regs_pkg::REG_DIR1:     nxt_cur.regs.direction[1] = rx_shift_ff;
                                    gpio_regs_pkg::REG_DRV0_LO:  nxt_cur.regs.drive[0]     = rx_shift_ff;
                                    gpio_regs_pkg::REG_DRV0_HI:  nxt_cur.regs.drive[1]     = rx_shift_ff;
                                    gpio_regs_pkg::REG_DRV1_LO:  nxt_cur.regs.drive[2]     = rx_shift_ff;
                                    gpio_regs_pkg::REG_DRV1_HI:  nxt_cur.regs.drive[3]     = rx_shift_ff;
                                    gpio_regs_pkg::REG_HOLD0:    nxt_cur.regs.hold_en[0]   = rx_shift_ff;
                                    gpio_regs_pkg::REG_HOLD1:    nxt_cur.regs.hold_en[1]   = rx_shift_ff;
                                    gpio_regs_pkg::REG_PULLEN0:  nxt_cur.regs.pull_en[0]   = rx_shift_ff;
                                    gpio_regs_pkg::REG_PULLEN1:  nxt_cur.regs.pull_en[1]   = rx_shift_ff;
                                    gpio_regs_pkg::REG_PULLSEL0: nxt_cur.regs.pull_sel[0]  = rx_shift_ff;
                                    gpio_regs_pkg::REG_PULLSEL1: nxt_cur.regs.pull_sel[1]  = rx_shift_ff;
                                    gpio_regs_pkg::REG_MASK0:    nxt_cur.regs.irq_mask[0]  = rx_shift_ff;
                                    gpio_regs_pkg::REG_MASK1:    nxt_cur.regs.irq_mask[1]  = rx_shift_ff;
                                    gpio_regs_pkg::REG_DRVTYPE:  nxt_cur.regs.drv_type     = rx_shift_ff;
                                    // Read-only and unknown codes land here
                                    default:                     nxt_cur.regs              = cur_ff.regs;
                                endcase
                            end
                            default:
                            begin
                                nxt_cur.ack_drv = 1'b0;
                            end
                        endcase
                    end
                end
            end

            // Falling serial clock: present the next data line value
            if (scl_fall)
            begin
                // Acknowledge in the ninth slot, else the read bit, MSB first
                // A one bit releases the line; the pull-up gives the high level
                nxt_cur.sda_low = (cur_ff.ack_drv && (cur_ff.bit_cnt == gpio_regs_pkg::ACK_SLOT))
                    || ((cur_ff.phase == gpio_regs_pkg::PH_RDATA)
                        && (cur_ff.bit_cnt < gpio_regs_pkg::ACK_SLOT)
                        && !cur_ff.tx[3'h7 - cur_ff.bit_cnt[2:0]]);
            end
        end
    end

    // State register with synchronous active-low reset
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            // Clear everything, then set the non-zero defaults
            cur_ff                <= '0;
            cur_ff.phase          <= gpio_regs_pkg::PH_IDLE;
            cur_ff.ptr            <= gpio_regs_pkg::RST_PTR;
            // Lines idle high, so no false edge follows reset
            cur_ff.scl_s1         <= 1'b1;
            cur_ff.scl_s2         <= 1'b1;
            cur_ff.scl_s3         <= 1'b1;
            cur_ff.sda_s1         <= 1'b1;
            cur_ff.sda_s2         <= 1'b1;
            cur_ff.sda_s3         <= 1'b1;
            cur_ff.regs.out_val   <= {2{gpio_regs_pkg::RST_OUT}};
            cur_ff.regs.invert    <= {2{gpio_regs_pkg::RST_INV}};
            cur_ff.regs.direction <= {2{gpio_regs_pkg::RST_DIR}};
            cur_ff.regs.drive     <= {4{gpio_regs_pkg::RST_DRV}};
            cur_ff.regs.hold_en   <= {2{gpio_regs_pkg::RST_HOLD}};
            cur_ff.regs.pull_en   <= {2{gpio_regs_pkg::RST_PULLEN}};
            cur_ff.regs.pull_sel  <= {2{gpio_regs_pkg::RST_PULLSEL}};
            cur_ff.regs.irq_mask  <= {2{gpio_regs_pkg::RST_MASK}};
            cur_ff.regs.drv_type  <= gpio_regs_pkg::RST_DRVTYPE;
        end
        else
        begin
            // Take the whole next state
            cur_ff <= nxt_cur;
        end
    end

    // Open-drain data line: only ever pulled low
    assign o_sda_out  = 1'b0;
    // Enable low only while pulling; released line reads high
    assign o_sda_oe_b = ~cur_ff.sda_low;

    // Pin drivers: value always present, enabled only where direction is zero
    assign o_port0_pin_out  = cur_ff.regs.out_val[0];
    assign o_port1_pin_out  = cur_ff.regs.out_val[1];
    // Enable low drives the pin
    assign o_port0_pin_oe_b = cur_ff.regs.direction[0];
    assign o_port1_pin_oe_b = cur_ff.regs.direction[1];

    // Extended pad controls straight from their registers
    assign o_drive_strength     = cur_ff.regs.drive;
    assign o_hold_enable        = cur_ff.regs.hold_en;
    assign o_pull_enable        = cur_ff.regs.pull_en;
    assign o_pull_select        = cur_ff.regs.pull_sel;
    assign o_irq_mask           = cur_ff.regs.irq_mask;
    assign o_output_driver_type = cur_ff.regs.drv_type;

endmodule // gpio_expander_register_file

// [tb/gpio_expander_register_file_properties.sv]
// Pin-level timing and reset checks for the port expander register file
`timescale 1ns/1ps
module gpio_expander_register_file_properties (
    input wire logic        i_mclk,
    input wire logic        i_rst_b,
    input wire logic        i_scl,
    input wire logic        o_sda_oe_b,
    input wire logic [7:0]  o_port0_pin_out,
    input wire logic [7:0]  o_port1_pin_oe_b,
    input wire logic [31:0] o_drive_strength,
    input wire logic [15:0] o_irq_mask
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // Power-up values seen as reset lets go
    property p_rst_pin; $rose(i_rst_b) |-> o_port0_pin_out == 8'hFF && o_port1_pin_oe_b == 8'hFF;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("pin reset value wrong");
    property p_rst_pad; $rose(i_rst_b) |-> o_drive_strength == '1 ##0 o_irq_mask == '1; endproperty
    a_rst_pad: assert property (p_rst_pad) else $error("pad reset value wrong");
    // Registers move only just after a bus clock rise that ends a data byte
    property p_out_w; $changed(o_port0_pin_out) |-> i_scl && $past(i_scl, 2); endproperty
    a_out_w: assert property (p_out_w) else $error("output moved off a write");
    property p_dir_w; $changed(o_port1_pin_oe_b) |-> $past(i_scl, 2) ##0 i_scl; endproperty
    a_dir_w: assert property (p_dir_w) else $error("direction moved off a write");
    property p_drv_w; $changed(o_drive_strength) |-> i_scl && $stable(i_scl); endproperty
    a_drv_w: assert property (p_drv_w) else $error("drive moved off a write");
    property p_msk_w; $changed(o_irq_mask) |-> i_scl ##1 i_scl; endproperty
    a_msk_w: assert property (p_msk_w) else $error("mask moved off a write");
    // Data line is taken and released only while the bus clock is low
    property p_ack; $fell(o_sda_oe_b) |-> !i_scl && !$past(i_scl, 2); endproperty
    a_ack: assert property (p_ack) else $error("data pulled with clock high");
    property p_rel; $rose(o_sda_oe_b) |-> !i_scl [*3]; endproperty
    a_rel: assert property (p_rel) else $error("data released with clock high");
    c_wr: cover property ($changed(o_port0_pin_out));
    c_ack: cover property ($fell(o_sda_oe_b));
    c_drv: cover property ($changed(o_drive_strength));
endmodule // gpio_expander_register_file_properties
bind gpio_expander_register_file gpio_expander_register_file_properties u_props (.i_mclk,
    .i_rst_b, .i_scl, .o_sda_oe_b, .o_port0_pin_out, .o_port1_pin_oe_b, .o_drive_strength,
    .o_irq_mask);

// [tb/i2c_master_model.sv]
// Serial bus master model, clock and data paced by the link tick
`timescale 1ns/1ps
module i2c_master_model (
    input  wire logic i_tick,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    // Lines idle high; the clock stands still between frames
    initial o_scl = 1'b1;
    initial o_sda = 1'b1;
    task automatic w(input int n); repeat (n) @(posedge i_tick); endtask
    // Start (1,0) or stop (0,1): data moves while the clock is high
    task automatic cond(input logic a, input logic b);
        w(2); o_sda <= a;
        w(3); o_scl <= 1'b1;
        w(5); o_sda <= b;
        w(5); o_scl <= b;
    endtask
    // One slot: data set with clock low, sampled at the end of the high phase
    task automatic bit_x(input logic v, output logic r);
        w(2); o_sda <= v;
        w(3); o_scl <= 1'b1;
        w(5); r = i_sda;
        o_scl <= 1'b0;
    endtask
    // Nine slots, most significant first; the last is the acknowledge
    task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bit_x(d[i], q[i]);
    endtask
endmodule // i2c_master_model

// [tb/gpio_expander_register_file_test.sv]
// Self-checking bench: register map, pin paths and bus handshake
`timescale 1ns/1ps
module gpio_expander_register_file_test;
    localparam logic [6:0] ADR = {5'h1D, 2'b10};
    logic i_mclk, tick, rst_b, sda_o, oe_b, m_scl, m_sda;
    logic [7:0] e0, e1, q0, q1, d0, d1, dty, mdl [256];
    logic [15:0] hld, pen, psl, msk;
    logic [31:0] drv;
    int n_fail, samples_checked, cyc;
    // Wire levels from every party's enables
    wire sda = m_sda & (oe_b | sda_o);
    wire [7:0] p0 = (~d0 & q0) | (d0 & e0);
    wire [7:0] p1 = (~d1 & q1) | (d1 & e1);
    gpio_expander_register_file #(.DEV_ADDR_HI(5'h1D)) DUT (.i_mclk(i_mclk), .i_rst_b(rst_b),
        .i_scl(m_scl), .i_sda(sda), .o_sda_out(sda_o), .o_sda_oe_b(oe_b), .i_addr_sel(2'b10),
        .i_port0_pin(p0), .o_port0_pin_out(q0), .o_port0_pin_oe_b(d0), .i_port1_pin(p1),
        .o_port1_pin_out(q1), .o_port1_pin_oe_b(d1), .o_drive_strength(drv), .o_hold_enable(hld),
        .o_pull_enable(pen), .o_pull_select(psl), .o_irq_mask(msk), .o_output_driver_type(dty));
    i2c_master_model m (.i_tick(tick), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
    initial begin i_mclk = 1'b0; forever #20 i_mclk = ~i_mclk; end
    initial begin tick = 1'b0; #7; forever #40 tick = ~tick; end
    // Codes 00h..08h then 40h..4Fh
    function automatic logic [7:0] cd(input int i); return (i < 9) ? 8'(i) : 8'(i + 55);
    endfunction
    // Expected read: input bytes rebuilt from model direction, output, external drive and inversion, others from the model
    function automatic logic [7:0] ex(input logic [7:0] c);
        logic [7:0] e, dr;
        e = c[0] ? e1 : e0;
        dr = mdl[c + 8'h06];
        return (c > 8'h01) ? mdl[c] : ((~dr & mdl[c + 8'h02]) | (dr & e)) ^ mdl[c + 8'h04];
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end
    endtask
    // One bus transfer: write v to code c, or read code c back
    task automatic xfer(input logic [7:0] c, input logic rd, input logic [7:0] v);
        logic [8:0] q;
        m.cond(1'b1, 1'b0);
        m.xbyte({ADR, 2'b01}, q);
        chk(q[0], 1'b0);
        m.xbyte({c, 1'b1}, q);
        if (rd) begin
            m.cond(1'b1, 1'b0);
            m.xbyte({ADR, 2'b11}, q);
            m.xbyte(9'h1FF, q);
            chk(q[8:1], ex(c));
        end else begin
            m.xbyte({v, 1'b1}, q);
            if (c inside {[8'h02:8'h07], [8'h40:8'h4B], 8'h4F}) mdl[c] = v;
        end
        m.cond(1'b0, 1'b1);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard well above the expected run of about 55500 cycles
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin n_fail++; results(); end
    end
    initial begin
        rst_b = 1'b0; e0 = 8'hC3; e1 = 8'h3C; n_fail = 0; samples_checked = 0; cyc = 0;
        for (int i = 0; i < 256; i++)
            mdl[i] = (i inside {2, 3, 6, 7, [64:67], [72:75]}) ? 8'hFF : 8'h00;
        repeat (8) @(posedge i_mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge i_mclk);
        for (int i = 0; i < 25; i++) xfer(cd(i), 1'b1, 8'h00);
        for (int i = 0; i < 25; i++) xfer(cd(i), 1'b0, cd(i) ^ 8'h5A);
        for (int i = 0; i < 25; i++) xfer(cd(i), 1'b1, 8'h00);
        chk({d1, d0, q1, q0}, {mdl[7], mdl[6], mdl[3], mdl[2]});
        chk(drv, {mdl[67], mdl[66], mdl[65], mdl[64]});
        chk({hld, pen}, {mdl[69], mdl[68], mdl[71], mdl[70]});
        chk({psl, msk}, {mdl[73], mdl[72], mdl[75], mdl[74]});
        chk(dty, mdl[79]);
        chk(sda_o, 1'b0);
        results();
    end
endmodule // gpio_expander_register_file_test
